// ### verilog/cmp_status_defs.svh
// Register offsets, field positions and reset values of the comparator status block.
`ifndef CMP_STATUS_DEFS_SVH
`define CMP_STATUS_DEFS_SVH

`define CSF_ADDR_STATUS      8'h94
`define CSF_ADDR_CTRL        8'h98
`define CSF_ADDR_IRQ_STATUS  8'h9c
`define CSF_ADDR_IRQ_MASK    8'ha0

`define CSF_STATUS_RESET     8'h00
`define CSF_CTRL_RESET       8'h00
`define CSF_IRQ_RESET        4'h0
`define CSF_HYST_RESET       2'h0

`define CSF_FLAG_MSB         7
`define CSF_FLAG_LSB         4
`define CSF_LIVE_MSB         3
`define CSF_LIVE_LSB         0
`define CSF_HYST_BCD_MSB     3
`define CSF_HYST_BCD_LSB     2
`define CSF_HYST_A_MSB       1
`define CSF_HYST_A_LSB       0
`define CSF_CTRL_IRQ_EN_MSB  7
`define CSF_CTRL_IRQ_EN_LSB  4
`define CSF_CTRL_PWR_EN_MSB  3
`define CSF_CTRL_PWR_EN_LSB  0

`define CSF_CHANNELS         4

`endif

// ### verilog/cmp_status_pkg.sv
// Types shared by the comparator status block.
`default_nettype none
package cmp_status_pkg;

  typedef struct packed {
    logic [3:0] irq_enable;
    logic [3:0] power_enable;
  } cmp_ctrl_t;

  typedef struct packed {
    logic [1:0] bcd;
    logic [1:0] a;
  } cmp_hyst_t;

endpackage
`default_nettype wire

// ### verilog/cmp_sync_edge.sv
// Two-flop synchroniser with toggle detection for one comparator output.
`timescale 1ns/100ps
`default_nettype none
module cmp_sync_edge (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      toggle_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o  = sync_q;
  assign toggle_o = sync_q ^ prev_q;

endmodule // cmp_sync_edge
`default_nettype wire

// ### verilog/comparator_status_flags.sv
// Comparator status and interrupt flag register bank with an Avalon-MM slave.
//
// Summary of operation
// RULE_01 - A live output toggle sets that channel's flag while its interrupt is enabled.
// RULE_02 - Flags stay set until software clears them; hardware never clears them.
// RULE_03 - Read gives flags D..A in bits 7..4, live outputs D..A in 3..0.
// RULE_04 - A disabled comparator's live output bit reads as zero.
// RULE_05 - Writes store B/C/D hysteresis in bits 3..2, A hysteresis in bits 1..0.
// RULE_06 - Register sits at 0x94, resets to zero, hysteresis codes not read back.
// RULE_07 - Software sets a per-channel interrupt enable to allow flag setting.
// RULE_08 - Software sets a per-channel comparator enable; cleared means disabled.
// RULE_09 - Each comparator output is synchronised before edge detection.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_status_defs.svh"
module comparator_status_flags (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [3:0]  cmp_raw_i,
  output logic      [1:0]  cmp_a_hyst_code_o,
  output logic      [1:0]  cmp_bcd_hyst_code_o,
  output logic      [3:0]  cmp_power_enable_o,
  output logic             irq_o
);

  // Positions of the registers in the one-hot select vector.
  localparam int SEL_STATUS     = 0;
  localparam int SEL_CTRL       = 1;
  localparam int SEL_IRQ_STATUS = 2;
  localparam int SEL_IRQ_MASK   = 3;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr[7:2] == target[7:2]);
  endfunction

  // Turns a byte address into a one-hot register select; an unmapped address selects nothing.
  function automatic logic [3:0] reg_decode(input logic [7:0] addr);
    reg_decode                 = 4'h0;
    reg_decode[SEL_STATUS]     = addr_hit(addr, `CSF_ADDR_STATUS);
    reg_decode[SEL_CTRL]       = addr_hit(addr, `CSF_ADDR_CTRL);
    reg_decode[SEL_IRQ_STATUS] = addr_hit(addr, `CSF_ADDR_IRQ_STATUS);
    reg_decode[SEL_IRQ_MASK]   = addr_hit(addr, `CSF_ADDR_IRQ_MASK);
  endfunction

  // Sticky update shared by the flags and the interrupt status bits; a set beats a clear.
  function automatic logic [3:0] sticky_next(input logic [3:0] cur,
                                             input logic [3:0] set_bits,
                                             input logic [3:0] clr_bits);
    sticky_next = (cur & ~clr_bits) | set_bits;
  endfunction

  // Register state.
  cmp_status_pkg::cmp_ctrl_t ctrl_q;
  cmp_status_pkg::cmp_hyst_t hyst_q;
  logic [3:0]                irq_flag_q;
  logic [3:0]                irq_flag_d;
  logic [3:0]                irq_status_q;
  logic [3:0]                irq_status_d;
  logic [3:0]                irq_mask_q;
  logic [3:0]                flag_clr;
  logic [3:0]                irq_clr;

  // Comparator path.
  logic [3:0]                sync_level;
  logic [3:0]                sync_toggle;
  logic [3:0]                live_out;
  logic [3:0]                flag_set;

  // Bus handshake and decode.
  logic                      ack_q;
  logic                      req;
  logic                      wr_fire;
  logic                      byte0_wr;
  logic                      rd_capture;
  logic [3:0]                reg_sel;
  logic [3:0]                wr_sel;
  logic [31:0]               rdata_d;
  logic [31:0]               rdata_q;

  // A toggle near a clock edge settles in the first flop before the edge detector sees it.
  // RULE_09 sync each output.
  genvar ch;
  generate
    for (ch = 0; ch < `CSF_CHANNELS; ch++) begin : g_chan
      cmp_sync_edge u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   (cmp_raw_i[ch]),
        .level_o   (sync_level[ch]),
        .toggle_o  (sync_toggle[ch])
      );
    end
  endgenerate

  // Gating uses the same enable that switches the comparator on, so a comparator that is still settling after enable is not hidden.
  // RULE_04 force disabled low.
  // RULE_08 enable gates output.
  assign live_out = sync_level & ctrl_q.power_enable;

  // Enabling a comparator raises no flag by itself; only a toggle of its output does.
  // RULE_01 toggle sets flag.
  // RULE_07 interrupt enable gate.
  assign flag_set = sync_toggle & ctrl_q.power_enable & ctrl_q.irq_enable;

  // The slave inserts one wait cycle; the access completes on the second edge.
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_fire           = avs_write_i & ack_q;
  assign byte0_wr          = wr_fire & avs_byteenable_i[0];
  assign rd_capture        = avs_read_i & ~ack_q;
  assign avs_readdata_o    = rdata_q;

  // Writes reach a register only at the edge that completes the access.
  assign reg_sel = reg_decode(avs_address_i);
  assign wr_sel  = {4{byte0_wr}} & reg_sel;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // RULE_03 read layout.
  // RULE_06 hysteresis not read back.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addr_hit(avs_address_i, `CSF_ADDR_STATUS)) begin
      rdata_d[`CSF_FLAG_MSB:`CSF_FLAG_LSB] = irq_flag_q;
      rdata_d[`CSF_LIVE_MSB:`CSF_LIVE_LSB] = live_out;
    end else if (addr_hit(avs_address_i, `CSF_ADDR_CTRL)) begin
      rdata_d[7:0] = ctrl_q;
    end else if (addr_hit(avs_address_i, `CSF_ADDR_IRQ_STATUS)) begin
      rdata_d[3:0] = irq_status_q;
    end else if (addr_hit(avs_address_i, `CSF_ADDR_IRQ_MASK)) begin
      rdata_d[3:0] = irq_mask_q;
    end
  end

  // Read data are taken in the first cycle so that they stand registered in the completing cycle.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_capture) begin
      rdata_q <= rdata_d;
    end
  end

  // Writing a zero to a flag bit clears it; writing a one leaves it alone.
  assign flag_clr   = wr_sel[SEL_STATUS] ? ~avs_writedata_i[`CSF_FLAG_MSB:`CSF_FLAG_LSB] : 4'h0;
  assign irq_flag_d = sticky_next(irq_flag_q, flag_set, flag_clr);

  // RULE_02 sticky flags, set wins.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_flag_q <= `CSF_IRQ_RESET;
    end else begin
      irq_flag_q <= irq_flag_d;
    end
  end

  // The hysteresis codes are write only here; reads of these bits show the live outputs.
  // RULE_05 store hysteresis codes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hyst_q.a   <= `CSF_HYST_RESET;
      hyst_q.bcd <= `CSF_HYST_RESET;
    end else if (wr_sel[SEL_STATUS]) begin
      hyst_q.a   <= avs_writedata_i[`CSF_HYST_A_MSB:`CSF_HYST_A_LSB];
      hyst_q.bcd <= avs_writedata_i[`CSF_HYST_BCD_MSB:`CSF_HYST_BCD_LSB];
    end
  end

  assign cmp_a_hyst_code_o   = hyst_q.a;
  assign cmp_bcd_hyst_code_o = hyst_q.bcd;

  // A channel's flag can only be set while both of its enables are on.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_q <= `CSF_CTRL_RESET;
    end else if (wr_sel[SEL_CTRL]) begin
      ctrl_q.irq_enable   <= avs_writedata_i[`CSF_CTRL_IRQ_EN_MSB:`CSF_CTRL_IRQ_EN_LSB];
      ctrl_q.power_enable <= avs_writedata_i[`CSF_CTRL_PWR_EN_MSB:`CSF_CTRL_PWR_EN_LSB];
    end
  end

  // The comparator enables also leave the block to switch the analog comparators on and off.
  assign cmp_power_enable_o = ctrl_q.power_enable;

  // Interrupt status records every flag-set event and is cleared by writing ones.
  assign irq_clr      = wr_sel[SEL_IRQ_STATUS] ? avs_writedata_i[3:0] : 4'h0;
  assign irq_status_d = sticky_next(irq_status_q, flag_set, irq_clr);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_status_q <= `CSF_IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // The mask gates only the interrupt line; the status bits keep recording events.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_mask_q <= `CSF_IRQ_RESET;
    end else if (wr_sel[SEL_IRQ_MASK]) begin
      irq_mask_q <= avs_writedata_i[3:0];
    end
  end

  // The line is an OR of registers, so it cannot glitch between edges.
  assign irq_o = |(irq_status_q & irq_mask_q);

endmodule // comparator_status_flags
`default_nettype wire

// ### sim/comparator_status_flags_monitor.sv
// Checker for the comparator status register bank.
`timescale 1ns/100ps
`default_nettype none
module comparator_status_flags_monitor (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [3:0]  cmp_raw_i,
  input  wire logic [1:0]  cmp_a_hyst_code_o,
  input  wire logic [1:0]  cmp_bcd_hyst_code_o,
  input  wire logic [3:0]  cmp_power_enable_o,
  input  wire logic        irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [2:0] calm_q;
  wire        ack  = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire        at94 = avs_address_i[7:2] == 6'h25;
  wire        rd94 = ack & avs_read_i & at94;
  // Counts edges over which the raw comparator inputs have not moved.
  always_ff @(posedge clk_sys_i) begin
    calm_q <= (rst_i || $changed(cmp_raw_i)) ? 3'h0 : (calm_q == 3'h7 ? calm_q : calm_q + 3'h1);
  end
  a_one_wait: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("wait state count wrong");
  a_upper_zero: assert property (ack && avs_read_i |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_live_off: assert property (rd94 |-> (avs_readdata_o[3:0] & ~$past(cmp_power_enable_o)) == 4'h0)
    else $error("disabled live bit set");
  a_live_sync: assert property (rd94 && calm_q > 3'h4 |-> avs_readdata_o[3:0] == (cmp_raw_i & $past(cmp_power_enable_o)))
    else $error("live bits wrong");
  a_hyst_store: assert property (ack && avs_write_i && at94 && avs_byteenable_i[0]
    |=> {cmp_bcd_hyst_code_o, cmp_a_hyst_code_o} == $past(avs_writedata_i[3:0]))
    else $error("hysteresis not stored");
  a_hyst_keep: assert property (!(ack && avs_write_i && at94) |=> $stable({cmp_bcd_hyst_code_o, cmp_a_hyst_code_o}))
    else $error("hysteresis changed");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(cmp_raw_i, 3) != $past(cmp_raw_i, 4) || $past(ack & avs_write_i))
    else $error("interrupt without cause");
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(ack & avs_write_i) || $past(rst_i))
    else $error("interrupt cleared by hardware");
  a_unmapped_zero: assert property (ack && avs_read_i && !(avs_address_i[7:2] inside {6'h25, 6'h26, 6'h27, 6'h28})
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  c_flag_read: cover property (rd94 && avs_readdata_o[7:4] != 4'h0);
  c_irq_rise: cover property ($rose(irq_o));
  c_irq_fall: cover property ($fell(irq_o));
endmodule // comparator_status_flags_monitor
bind comparator_status_flags comparator_status_flags_monitor u_comparator_status_flags_monitor (.*);
`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench for the comparator status register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        avs_waitrequest_o, irq_o;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdata;
  logic [3:0]  avs_byteenable_i = 4'hf, cmp_raw_i = 4'h0, cmp_power_enable_o;
  logic [1:0]  cmp_a_hyst_code_o, cmp_bcd_hyst_code_o;
  int          err_total = 0, cmp_count = 0;
  logic [23:0] rows [5] = '{24'h985a5a, 24'ha00f0f, 24'h94ff00, 24'h80ff00, 24'h980000};
  comparator_status_flags u_comparator_status_flags (.*);
  always #2 clk_sys_i = ~clk_sys_i;
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdata, {24'h0, e});
  endtask
  task automatic irq(input logic e);
    @(posedge clk_sys_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h94 + 8'(i * 4), 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({28'h0, cmp_bcd_hyst_code_o, cmp_a_hyst_code_o}, 32'h0000_000f);
    $display("test table done");
    cmp_raw_i <= 4'hf;
    repeat (4) @(posedge clk_sys_i);
    rd(8'h94, 8'h00);
    bus(1'b1, 8'h98, 8'h35);
    rd(8'h94, 8'h05);
    chk({28'h0, cmp_power_enable_o}, 32'h0000_0005);
    bus(1'b1, 8'h98, 8'h3f);
    bus(1'b1, 8'ha0, 8'h0f);
    cmp_raw_i <= 4'h0;
    repeat (4) @(posedge clk_sys_i);
    irq(1'b1);
    rd(8'h94, 8'h30);
    rd(8'h9c, 8'h03);
    bus(1'b1, 8'h94, 8'he0);
    rd(8'h94, 8'h20);
    chk({28'h0, cmp_bcd_hyst_code_o, cmp_a_hyst_code_o}, 32'h0000_0000);
    cmp_raw_i <= 4'h1;
    repeat (4) @(posedge clk_sys_i);
    rd(8'h94, 8'h31);
    irq(1'b1);
    $display("test flags done");
    bus(1'b1, 8'ha0, 8'h00);
    irq(1'b0);
    bus(1'b1, 8'h9c, 8'h03);
    bus(1'b1, 8'ha0, 8'h0f);
    irq(1'b0);
    cmp_raw_i <= 4'h0;
    repeat (4) @(posedge clk_sys_i);
    irq(1'b1);
    bus(1'b1, 8'h9c, 8'h01);
    irq(1'b0);
    $display("test interrupt done");
    avs_byteenable_i <= 4'he;
    bus(1'b1, 8'h94, 8'h0f);
    avs_byteenable_i <= 4'hf;
    rd(8'h94, 8'h30);
    chk({28'h0, cmp_bcd_hyst_code_o, cmp_a_hyst_code_o}, 32'h0000_0000);
    $display("test byte enable done");
    bus(1'b1, 8'h94, 8'hff);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(8'h94, 8'h00);
    rd(8'h98, 8'h00);
    rd(8'ha0, 8'h00);
    chk({28'h0, cmp_bcd_hyst_code_o, cmp_a_hyst_code_o}, 32'h0000_0000);
    chk({28'h0, cmp_power_enable_o}, 32'h0000_0000);
    irq(1'b0);
    $display("test second reset done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
